// ### shared/sdi_pkg.sv
`default_nettype none
package sdi_pkg;
    // =====================================================
    // datagram framing
    localparam int unsigned DG_BITS     = 40;
    localparam int unsigned DATA_BITS   = 32;
    localparam int unsigned ADDR_BITS   = 7;
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned WR_POS      = 39;
    localparam int unsigned ADDR_HI     = 38;
    localparam int unsigned ADDR_LO     = 32;
    localparam int unsigned DATA_HI     = 31;
    localparam int unsigned NREGS       = 128;
    localparam int unsigned CNT_BITS    = 6;
    // =====================================================
    // register access classes
    localparam logic [1:0] ACC_WO = 2'h0;
    localparam logic [1:0] ACC_RW = 2'h1;
    localparam logic [1:0] ACC_RO = 2'h2;
    // =====================================================
    // timing: host serial clock half period in system clocks
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned SCK_NS      = 400;
    localparam int unsigned HALF_CYC    = (SCK_NS * (CLK_HZ / 1_000_000) / 1000) / 2;
    localparam int unsigned DIV_BITS    = 4;
    localparam int unsigned GAP_CYC     = 4;
    localparam logic [CNT_BITS-1:0] CNT_FULL = 6'h28;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 6'h00;
endpackage : sdi_pkg
`default_nettype wire

// ### shared/sdi_if.sv
`default_nettype none
interface sdi_if;
    logic sck;
    logic mosi;
    logic miso;
    logic cs_n;
    modport device (input sck, input mosi, input cs_n, output miso);
    modport host   (output sck, output mosi, output cs_n, input miso);
endinterface : sdi_if
`default_nettype wire

// ### hw/sdi_device.sv
// Functional notes
// (R1) every transaction is one 40-bit datagram
// (R2) host holds select low whole datagram
// (R3) address byte then four data bytes
// (R4) full 32 data bits always exchanged
// (R5) address byte: direction bit over 7-bit address
// (R6) top bit 0: read, data not stored
// (R7) top bit 1: write, store 32 bits
// (R8) status byte sent in address position
// (R9) write-only, read-write and read-only registers
// (R10) msb first, sample rising, shift falling
// (R11) select rise latches last 40 bits
// (R12) reply holds previous read or write data
// (R13) status latched at access end
// (R14) short datagram discarded, registers unchanged
`default_nettype none
module sdi_device (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    sdi_if.device                          link,
    input  wire logic [sdi_pkg::BYTE_BITS-1:0] status_in,
    input  wire logic [sdi_pkg::DATA_BITS-1:0] ro_data,
    input  wire logic [sdi_pkg::ADDR_BITS-1:0] ro_lo,
    output logic [sdi_pkg::DATA_BITS-1:0]  reg_wdata,
    output logic [sdi_pkg::ADDR_BITS-1:0]  reg_addr,
    output logic                           reg_wr,
    output logic [sdi_pkg::ADDR_BITS-1:0]  rd_addr
);
    // =====================================================
    // pin synchronisers, three stages each
    logic [2:0] sck_s_q;
    logic [2:0] mosi_s_q;
    logic [2:0] cs_s_q;
    logic       sck_f_q;
    logic       cs_f_q;
    logic       sck_f_d;
    logic       cs_f_d;
    assign sck_f_d = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
    assign cs_f_d  = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_f_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sck_s_q  <= 3'h7;
            mosi_s_q <= 3'h0;
            cs_s_q   <= 3'h7;
            sck_f_q  <= 1'b1;
            cs_f_q   <= 1'b1;
        end else begin
            sck_s_q  <= {sck_s_q[1:0], link.sck};
            mosi_s_q <= {mosi_s_q[1:0], link.mosi};
            cs_s_q   <= {cs_s_q[1:0], link.cs_n};
            sck_f_q  <= sck_f_d;
            cs_f_q   <= cs_f_d;
        end
    end
    // =====================================================
    // edge decode
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic active;
    assign sck_rise = active && sck_f_d && !sck_f_q;                   // R10
    assign sck_fall = active && !sck_f_d && sck_f_q;                   // R10
    assign cs_rise  = cs_f_d && !cs_f_q;
    assign cs_fall  = !cs_f_d && cs_f_q;
    assign active   = !cs_f_q;                                         // R2
    // =====================================================
    // register storage and access classes
    logic [sdi_pkg::DATA_BITS-1:0] regs_q [sdi_pkg::NREGS];
    logic [1:0]                    acc_class [sdi_pkg::NREGS];
    genvar gi;
    generate
        for (gi = 0; gi < sdi_pkg::NREGS; gi++) begin : g_cls
            assign acc_class[gi] = (gi >= ro_lo) ? sdi_pkg::ACC_RO
                                 : (((gi % 2) == 1) ? sdi_pkg::ACC_RW : sdi_pkg::ACC_WO); // R9
        end
    endgenerate
    // =====================================================
    // shift register and datagram state
    logic [sdi_pkg::DG_BITS-1:0]   sh_q;
    logic [sdi_pkg::DG_BITS-1:0]   out_q;
    logic [sdi_pkg::CNT_BITS-1:0]  cnt_q;
    logic [sdi_pkg::DATA_BITS-1:0] reply_q;
    logic [sdi_pkg::BYTE_BITS-1:0] stat_q;
    logic                          miso_q;
    logic                          cmd_ok;
    logic                          cmd_wr;
    logic [sdi_pkg::ADDR_BITS-1:0] cmd_addr;
    logic [sdi_pkg::DATA_BITS-1:0] cmd_data;
    logic [sdi_pkg::DATA_BITS-1:0] rd_word;
    logic [1:0]                    cmd_cls;
    assign cmd_ok   = cs_rise && (cnt_q == sdi_pkg::CNT_FULL);        // R1 R14
    assign cmd_wr   = sh_q[sdi_pkg::WR_POS];                          // R5 R6 R7
    assign cmd_addr = sh_q[sdi_pkg::ADDR_HI:sdi_pkg::ADDR_LO];        // R5
    assign cmd_data = sh_q[sdi_pkg::DATA_HI:0];                       // R3 R4
    assign cmd_cls  = acc_class[cmd_addr];
    assign rd_word  = (cmd_cls == sdi_pkg::ACC_RO) ? ro_data
                    : ((cmd_cls == sdi_pkg::ACC_RW) ? regs_q[cmd_addr] : '0);
    // shift in on rise, count saturating at a full datagram
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sh_q  <= '0;
            cnt_q <= sdi_pkg::CNT_ZERO;
        end else if (cs_fall) begin
            cnt_q <= sdi_pkg::CNT_ZERO;
        end else if (sck_rise) begin
            sh_q <= {sh_q[sdi_pkg::DG_BITS-2:0], mosi_s_q[2]};        // R10 R11
            if (cnt_q != sdi_pkg::CNT_FULL) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end
    // outgoing frame: status then reply; overflow bits delayed by 40
    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_q  <= '0;
            miso_q <= 1'b0;
        end else if (cs_fall) begin
            out_q  <= {stat_q, reply_q};                              // R8 R12
            miso_q <= stat_q[sdi_pkg::BYTE_BITS-1];                   // R10
        end else if (sck_rise) begin
            out_q <= {out_q[sdi_pkg::DG_BITS-2:0], mosi_s_q[2]};      // R11
        end else if (sck_fall) begin
            miso_q <= out_q[sdi_pkg::DG_BITS-1];                      // R10
        end
    end
    // command latch on select release
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reply_q   <= '0;
            stat_q    <= '0;
            reg_wr    <= 1'b0;
            reg_addr  <= '0;
            reg_wdata <= '0;
            rd_addr   <= '0;
        end else begin
            reg_wr <= 1'b0;
            if (cs_rise) begin
                stat_q <= status_in;                                  // R13
            end
            if (cmd_ok) begin
                reg_addr <= cmd_addr;
                if (cmd_wr) begin
                    reply_q   <= cmd_data;                            // R12
                    reg_wdata <= cmd_data;                            // R7
                    reg_wr    <= (cmd_cls != sdi_pkg::ACC_RO);        // R7 R9
                end else begin
                    reply_q <= rd_word;                               // R6 R12
                    rd_addr <= cmd_addr;
                end
            end
        end
    end
    // writable register storage
    always_ff @(posedge clk) begin
        if (cmd_ok && cmd_wr && cmd_cls != sdi_pkg::ACC_RO) begin
            regs_q[cmd_addr] <= cmd_data;                             // R7
        end
    end
    // link output
    assign link.miso = miso_q;
endmodule : sdi_device
`default_nettype wire

// ### hw/sdi_host.sv
`default_nettype none
module sdi_host (
    input  wire logic                              clk,
    input  wire logic                              rstn,
    sdi_if.host                                    link,
    input  wire logic                              req_valid,
    input  wire logic                              req_write,
    input  wire logic [sdi_pkg::ADDR_BITS-1:0]     req_addr,
    input  wire logic [sdi_pkg::DATA_BITS-1:0]     req_data,
    output logic                                   req_ready,
    output logic                                   rsp_valid,
    output logic [sdi_pkg::BYTE_BITS-1:0]          rsp_status,
    output logic [sdi_pkg::DATA_BITS-1:0]          rsp_data
);
    typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_GAP} sdi_hst_e;
    localparam logic [sdi_pkg::DIV_BITS-1:0] HALF_M1 = sdi_pkg::DIV_BITS'(sdi_pkg::HALF_CYC - 1);
    localparam logic [sdi_pkg::DIV_BITS-1:0] GAP_M1  = sdi_pkg::DIV_BITS'(sdi_pkg::GAP_CYC - 1);
    sdi_hst_e st_q;
    logic [sdi_pkg::DIV_BITS-1:0] div_q;
    logic [sdi_pkg::CNT_BITS-1:0] cnt_q;
    logic [sdi_pkg::DG_BITS-1:0]  tx_q;
    logic [sdi_pkg::DG_BITS-1:0]  rx_q;
    logic [2:0] miso_s_q;
    logic [sdi_pkg::DG_BITS-1:0]  rx_nx;
    logic sck_q;
    logic cs_n_q;
    logic mosi_q;
    logic tick;
    assign tick  = (div_q == HALF_M1);
    assign rx_nx = {rx_q[sdi_pkg::DG_BITS-2:0], miso_s_q[2]};                 // R10
    // =====================================================
    // miso synchroniser
    always_ff @(posedge clk) begin
        if (!rstn) miso_s_q <= 3'h0;
        else miso_s_q <= {miso_s_q[1:0], link.miso};
    end
    // =====================================================
    // framing: select low for 40 clocks, msb first, mode 3
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q       <= H_IDLE;
            div_q      <= '0;
            cnt_q      <= '0;
            tx_q       <= '0;
            rx_q       <= '0;
            sck_q      <= 1'b1;
            cs_n_q     <= 1'b1;
            mosi_q     <= 1'b0;
            req_ready  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_status <= '0;
            rsp_data   <= '0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            div_q     <= tick ? '0 : div_q + 4'h1;
            unique case (st_q)
                H_IDLE: begin
                    div_q <= '0;
                    if (req_valid && !req_ready) begin
                        req_ready <= 1'b1;
                        tx_q      <= {req_write, req_addr, req_data};    // R3 R5
                        mosi_q    <= req_write;                          // R10
                        cs_n_q    <= 1'b0;                               // R2
                        cnt_q     <= '0;
                        st_q      <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (tick) begin
                        st_q <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    // reply bit taken at the end of the high phase, past both synchronisers
                    if (tick && sck_q) begin
                        if (cnt_q != sdi_pkg::CNT_ZERO) begin
                            rx_q   <= rx_nx;                             // R10
                            mosi_q <= tx_q[sdi_pkg::DG_BITS-2];          // R10
                            tx_q   <= {tx_q[sdi_pkg::DG_BITS-2:0], 1'b0};
                        end
                        if (cnt_q == sdi_pkg::CNT_FULL) begin            // R1
                            cs_n_q     <= 1'b1;
                            rsp_valid  <= 1'b1;
                            rsp_status <= rx_nx[sdi_pkg::WR_POS:sdi_pkg::ADDR_LO];
                            rsp_data   <= rx_nx[sdi_pkg::DATA_HI:0];
                            st_q       <= H_GAP;
                        end else begin
                            sck_q <= 1'b0;
                        end
                    end else if (tick) begin
                        sck_q <= 1'b1;
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                H_GAP: begin
                    if (div_q == GAP_M1) begin
                        st_q <= H_IDLE;
                    end
                end
            endcase
        end
    end
    assign link.sck  = sck_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = mosi_q;
endmodule : sdi_host
`default_nettype wire

// ### verif/sdi_checker.sv
`default_nettype none
module sdi_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic cs_n
);
    // ==========
    // bit count of the open frame
    logic [5:0] nbit_q;
    logic       sck_q;
    always_ff @(posedge clk) begin
        sck_q  <= sck;
        nbit_q <= (!rstn || cs_n) ? 6'h00 : nbit_q + {5'h00, sck & !sck_q};
    end
    // ==========
    // link rules
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_frame_forty_bits: assert property ($rose(cs_n) |-> nbit_q == 6'h28)
        else $error("frame not forty clocks");
    a_select_held: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("select dropped early");
    a_lead_time: assert property ($fell(cs_n) |-> sck [*3] ##[1:8] !sck)
        else $error("clock lead wrong");
    a_sck_half_period: assert property ($fell(sck) |-> !sck [*4] ##1 sck)
        else $error("clock low phase wrong");
    a_idle_clock_high: assert property (cs_n && $past(cs_n) |-> sck)
        else $error("clock moves while idle");
    a_mosi_steady: assert property (!cs_n && sck && $past(sck) && nbit_q != 6'h00 |-> $stable(mosi))
        else $error("host data moves while clock high");
    a_miso_steady: assert property (!cs_n && sck && $past(sck) && nbit_q != 6'h00 |-> $stable(miso))
        else $error("device data moves while clock high");
    a_end_gap: assert property ($rose(cs_n) |-> $past(sck) ##0 cs_n [*4])
        else $error("frame end or gap wrong");
    c_frame: cover property ($rose(cs_n));
    c_write: cover property ($fell(cs_n) ##1 mosi);
    c_read: cover property ($fell(cs_n) ##1 !mosi);
endmodule : sdi_checker
`default_nettype wire

// ### verif/spi_datagram_interface_test.sv
`default_nettype none
module spi_datagram_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, req_valid, req_write, req_ready, rsp_valid, reg_wr, reg_wr2, ok, w;
    logic [6:0]  req_addr, reg_addr, reg_addr2, ro_lo, a;
    logic [31:0] req_data, rsp_data, reg_wdata, reg_wdata2, ro_data, exp_d;
    logic [7:0]  rsp_status, status_in, stat_e;
    logic [39:0] mo_q, mi_q, mi2_q;
    logic [31:0] mem [128];
    bit          kn [128];
    int          n_mismatch, num_checks, seed, n_wr, n_wr2;
    sdi_if lk();
    sdi_if lk2();
    sdi_host sdi_host_i (.clk(clk), .rstn(rstn), .link(lk), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_status(rsp_status), .rsp_data(rsp_data));
    sdi_device sdi_device_i (.clk(clk), .rstn(rstn), .link(lk), .status_in(status_in), .ro_data(ro_data),
        .ro_lo(ro_lo), .reg_wdata(reg_wdata), .reg_addr(reg_addr), .reg_wr(reg_wr), .rd_addr());
    sdi_device sdi_device_i2 (.clk(clk), .rstn(rstn), .link(lk2), .status_in(status_in), .ro_data(ro_data),
        .ro_lo(ro_lo), .reg_wdata(reg_wdata2), .reg_addr(reg_addr2), .reg_wr(reg_wr2), .rd_addr());
    sdi_checker sdi_checker_i (.clk(clk), .rstn(rstn), .sck(lk.sck), .mosi(lk.mosi), .miso(lk.miso),
        .cs_n(lk.cs_n));
    // ==========
    // clock, wire monitors, store counters
    always #25 clk = ~clk;
    always @(posedge lk.sck) begin
        #5;
        mo_q <= {mo_q[38:0], lk.mosi};
        mi_q <= {mi_q[38:0], lk.miso};
    end
    always @(posedge lk2.sck) mi2_q <= {mi2_q[38:0], lk2.miso};
    always @(posedge clk) n_wr <= n_wr + int'(reg_wr);
    always @(posedge clk) n_wr2 <= n_wr2 + int'(reg_wr2);
    // ==========
    // compare, verdict, watchdog
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        #(50 * 60000);
        n_mismatch++;
        conclude();
    end
    // ==========
    // one host transfer with expectations from the model
    task automatic xfer(input logic wi, input logic [6:0] ai, input logic [31:0] d);
        int k;
        int c0;
        c0 = n_wr;
        @(negedge clk);
        {req_valid, req_write, req_addr, req_data} = {1'b1, wi, ai, d};
        for (k = 0; req_ready !== 1'b1 && k < 50; k++) @(negedge clk);
        req_valid = 1'b0;
        if (k >= 50) n_mismatch++;
        for (k = 0; rsp_valid !== 1'b1 && k < 2000; k++) @(negedge clk);
        if (k >= 2000) n_mismatch++;
        repeat (10) @(negedge clk);
        chk(mo_q, {wi, ai, d});
        if (ok) chk({rsp_status, rsp_data}, {stat_e, exp_d});
        if (ok) chk(mi_q, {stat_e, exp_d});
        chk(40'(n_wr - c0), 40'(wi && ai < ro_lo));
        if (wi && ai < ro_lo) chk({reg_addr, reg_wdata}, {ai, d});
        ok = wi || ai >= ro_lo || kn[ai];
        exp_d = wi ? d : (ai >= ro_lo ? ro_data : mem[ai]);
        if (wi && ai < ro_lo) {kn[ai], mem[ai]} = {1'b1, d};
        stat_e = status_in;
        status_in = 8'($random(seed));
    endtask : xfer
    // raw frame of n clocks on the second link
    task automatic raw(input int n, input logic [47:0] v);
        lk2.cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            {lk2.sck, lk2.mosi} = {1'b0, v[i]};
            repeat (4) @(negedge clk);
            lk2.sck = 1'b1;
            repeat (4) @(negedge clk);
        end
        {lk2.cs_n, lk2.mosi} = {1'b1, ~lk2.mosi};
        repeat (10) @(negedge clk);
    endtask : raw
    // ==========
    // main sequence
    initial begin
        {clk, rstn, req_valid, req_write, req_addr, req_data, ok} = '0;
        {lk2.sck, lk2.cs_n, lk2.mosi} = 3'h6;
        seed = 32'hd15703c6;
        ro_lo = 7'h60;
        ro_data = $random(seed);
        status_in = 8'($random(seed));
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        xfer(1'b1, 7'h05, 32'h0001_1f10);
        xfer(1'b0, 7'h05, 32'hffff_ffff);
        xfer(1'b0, 7'h61, 32'h0000_0000);
        xfer(1'b1, 7'h7f, 32'hdead_beef);
        xfer(1'b1, 7'h00, 32'h8000_0001);
        xfer(1'b0, 7'h05, 32'h0000_0000);
        repeat (14) begin
            w = 1'($random(seed));
            a = 7'($random(seed));
            if (!w && a < ro_lo) a[0] = 1'b1;
            xfer(w, a, $random(seed));
        end
        xfer(1'b0, 7'h05, 32'h0000_0000);
        a = 7'(n_wr2);
        raw(30, {17'h0, 1'b1, 7'h03, 23'h0});
        chk(40'(n_wr2), 40'(a));
        raw(48, {8'ha5, 1'b1, 7'h03, 32'h1234_5678});
        chk(40'(n_wr2), 40'(a + 7'h01));
        chk({reg_addr2, reg_wdata2}, {7'h03, 32'h1234_5678});
        chk(40'(mi2_q[7:0]), 40'h0000_0000_a5);
        conclude();
    end
endmodule : spi_datagram_interface_test
`default_nettype wire
